// [verilog/pmc_regs.vh]
// register offsets, field positions and reset values of the pwm channel
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
`define PMC_ADDR_MODE 3'h0
`define PMC_ADDR_CTRL 3'h1
`define PMC_ADDR_PER_LO 3'h2
`define PMC_ADDR_PER_HI 3'h3
`define PMC_ADDR_DUTY_LO 3'h4
`define PMC_ADDR_DUTY_HI 3'h5
`define PMC_ADDR_DEAD_LO 3'h6
`define PMC_ADDR_DEAD_HI 3'h7
`define PMC_MODE_RESET 8'h07
`define PMC_MODE_CH2_FAULT_PIN_EN 7
`define PMC_MODE_WM2 6
`define PMC_MODE_WM1 5
`define PMC_MODE_WM0 4
`define PMC_MODE_RL2 2
`define PMC_MODE_RL1 1
`define PMC_MODE_RL0 0
`define PMC_MODE_WMASK 8'hf7
`define PMC_CTRL_IE 7
`define PMC_CTRL_IF 6
`define PMC_CTRL_FS 5
`define PMC_CTRL_FPOL 4
`define PMC_CTRL_OPOL_HI 3
`define PMC_CTRL_OPOL_LO 2
`define PMC_CTRL_CK_HI 1
`define PMC_CTRL_CK_LO 0
`define PMC_CTRL_RESET 8'h00
`define PMC_DIV_8 8'h07
`define PMC_DIV_32 8'h1f
`define PMC_DIV_128 8'h7f
`endif

// [verilog/pmc_channel.v]
// pwm channel 0 with mode, reload, period, duty, dead time and fault logic
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_channel #(
    parameter WIDTH = 12
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [2:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire ch0_primary_enable_in,
    input wire ch0_secondary_enable_in,
    input wire [1:0] ch0_fault_level_select_in,
    input wire ch0_fault_pin_enable_in,
    input wire ch0_fault_pin_in,
    input wire ch2_fault_pin_in,
    output reg ch0_primary_out,
    output reg ch0_secondary_out,
    output wire ch0_irq_out,
    output wire ch2_fault_shutdown_out,
    output wire ch2_work_mode_out,
    output wire ch1_work_mode_out,
    output wire ch2_auto_reload_out,
    output wire ch1_auto_reload_out
);
    reg [7:0] mode_reg;
    reg [7:0] ctrl_reg;
    reg [7:0] per_lo_reg;
    reg [3:0] per_hi_reg;
    reg [7:0] duty_lo_reg;
    reg [3:0] duty_hi_reg;
    reg [7:0] dead_lo_reg;
    reg [3:0] dead_hi_reg;
    reg [WIDTH-1:0] per_pend_reg;
    reg [WIDTH-1:0] per_act_reg;
    reg [WIDTH-1:0] duty_act_reg;
    reg [WIDTH-1:0] dead_act_reg;
    reg [WIDTH-1:0] cnt_reg;
    reg [7:0] pre_reg;
    reg f0_s1_reg;
    reg f0_s2_reg;
    reg f2_s1_reg;
    reg f2_s2_reg;
    reg wm_sync_reg;
    wire run;
    wire tick;
    wire ovf;
    wire fault_act;
    wire wr_mode;
    wire wr_ctrl;
    wire [WIDTH-1:0] duty_val;
    wire [WIDTH-1:0] dead_val;
    reg [7:0] div_max;
    reg pri_act;
    reg sec_act;

    function sel;
        input [2:0] a;
        input [2:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    assign wr_mode = wr_in && sel(addr_in, `PMC_ADDR_MODE);
    assign wr_ctrl = wr_in && sel(addr_in, `PMC_ADDR_CTRL);
    assign duty_val = {duty_hi_reg, duty_lo_reg};
    assign dead_val = {dead_hi_reg, dead_lo_reg};

    // pin synchronisers
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            f0_s1_reg <= 1'b0;
            f0_s2_reg <= 1'b0;
            f2_s1_reg <= 1'b0;
            f2_s2_reg <= 1'b0;
        end else begin
            f0_s1_reg <= ch0_fault_pin_in;
            f0_s2_reg <= f0_s1_reg;
            f2_s1_reg <= ch2_fault_pin_in;
            f2_s2_reg <= f2_s1_reg;
        end
    end

    // fault level compared against selected polarity
    assign fault_act = ch0_fault_pin_enable_in &&
        (f0_s2_reg == ctrl_reg[`PMC_CTRL_FPOL]);
    assign ch2_fault_shutdown_out = mode_reg[`PMC_MODE_CH2_FAULT_PIN_EN] &&
        f2_s2_reg;
    assign ch2_work_mode_out = mode_reg[`PMC_MODE_WM2];
    assign ch1_work_mode_out = mode_reg[`PMC_MODE_WM1];
    assign ch2_auto_reload_out = mode_reg[`PMC_MODE_RL2];
    assign ch1_auto_reload_out = mode_reg[`PMC_MODE_RL1];
    assign ch0_irq_out = ctrl_reg[`PMC_CTRL_IE] &&
        ctrl_reg[`PMC_CTRL_IF];

    always @* begin
        case (ctrl_reg[`PMC_CTRL_CK_HI:`PMC_CTRL_CK_LO])
            2'b00: div_max = 8'h00;
            2'b01: div_max = `PMC_DIV_8;
            2'b10: div_max = `PMC_DIV_32;
            default: div_max = `PMC_DIV_128;
        endcase
    end

    assign run = ch0_primary_enable_in || ch0_secondary_enable_in;
    assign tick = run && (pre_reg >= div_max);
    // period value n gives n counting clocks per cycle
    assign ovf = tick && (cnt_reg + 1'b1 >= per_act_reg);

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            pre_reg <= 8'h00;
            cnt_reg <= {WIDTH{1'b0}};
        end else if (!run) begin
            pre_reg <= 8'h00;
            cnt_reg <= {WIDTH{1'b0}};
        end else begin
            pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
            if (ovf)
                cnt_reg <= {WIDTH{1'b0}};
            else if (tick)
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // registers and shadow copies
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            mode_reg <= `PMC_MODE_RESET;
            ctrl_reg <= `PMC_CTRL_RESET;
            per_lo_reg <= 8'h00;
            per_hi_reg <= 4'h0;
            duty_lo_reg <= 8'h00;
            duty_hi_reg <= 4'h0;
            dead_lo_reg <= 8'h00;
            dead_hi_reg <= 4'h0;
            per_pend_reg <= {WIDTH{1'b0}};
            per_act_reg <= {WIDTH{1'b0}};
            duty_act_reg <= {WIDTH{1'b0}};
            dead_act_reg <= {WIDTH{1'b0}};
        end else begin
            if (wr_mode)
                mode_reg <= wdata_in & `PMC_MODE_WMASK;
            if (wr_ctrl) begin
                ctrl_reg[`PMC_CTRL_IE] <= wdata_in[`PMC_CTRL_IE];
                ctrl_reg[4:0] <= wdata_in[4:0];
            end
            // set beats clear; flag only cleared by writing 0
            if (ovf)
                ctrl_reg[`PMC_CTRL_IF] <= 1'b1;
            else if (wr_ctrl && !wdata_in[`PMC_CTRL_IF])
                ctrl_reg[`PMC_CTRL_IF] <= 1'b0;
            if (fault_act)
                ctrl_reg[`PMC_CTRL_FS] <= 1'b1;
            else if (wr_ctrl && !wdata_in[`PMC_CTRL_FS])
                ctrl_reg[`PMC_CTRL_FS] <= 1'b0;
            if (wr_in && sel(addr_in, `PMC_ADDR_PER_HI))
                per_hi_reg <= wdata_in[3:0];
            if (wr_in && sel(addr_in, `PMC_ADDR_PER_LO)) begin
                per_lo_reg <= wdata_in;
                per_pend_reg <= {per_hi_reg, wdata_in};
            end
            if (wr_in && sel(addr_in, `PMC_ADDR_DUTY_LO))
                duty_lo_reg <= wdata_in;
            if (wr_in && sel(addr_in, `PMC_ADDR_DUTY_HI))
                duty_hi_reg <= wdata_in[3:0];
            if (wr_in && sel(addr_in, `PMC_ADDR_DEAD_LO))
                dead_lo_reg <= wdata_in;
            if (wr_in && sel(addr_in, `PMC_ADDR_DEAD_HI))
                dead_hi_reg <= wdata_in[3:0];
            // load at period boundary or while stopped, only when reload enabled
            if ((ovf || !run) && mode_reg[`PMC_MODE_RL0]) begin
                per_act_reg <= per_pend_reg;
                duty_act_reg <= duty_val;
                dead_act_reg <= dead_val;
            end
        end
    end

    // mode bit sampled at each period boundary and while stopped keeps waveform coherent
    always @(posedge ref_clk_in) begin
        if (rst_in)
            wm_sync_reg <= 1'b0;
        else if (ovf || !run)
            wm_sync_reg <= mode_reg[`PMC_MODE_WM0];
    end

    always @* begin
        if (wm_sync_reg) begin
            pri_act = cnt_reg < duty_act_reg;
            sec_act = cnt_reg < dead_act_reg;
        end else begin
            pri_act = cnt_reg < duty_act_reg;
            sec_act = cnt_reg >= duty_act_reg + dead_act_reg;
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            ch0_primary_out <= 1'b0;
            ch0_secondary_out <= 1'b0;
        end else if (fault_act || ctrl_reg[`PMC_CTRL_FS]) begin
            ch0_primary_out <= ch0_fault_level_select_in[1];
            ch0_secondary_out <= ch0_fault_level_select_in[0];
        end else begin
            ch0_primary_out <= ch0_primary_enable_in &&
                (pri_act ^ ctrl_reg[`PMC_CTRL_OPOL_HI]);
            ch0_secondary_out <= ch0_secondary_enable_in &&
                (sec_act ^ ctrl_reg[`PMC_CTRL_OPOL_LO]);
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in)
            rdata_out <= 8'h00;
        else if (rd_in) begin
            case (addr_in)
                `PMC_ADDR_MODE: rdata_out <= mode_reg;
                `PMC_ADDR_CTRL: rdata_out <= ctrl_reg;
                `PMC_ADDR_PER_LO: rdata_out <= per_lo_reg;
                `PMC_ADDR_PER_HI: rdata_out <= {4'h0, per_hi_reg};
                `PMC_ADDR_DUTY_LO: rdata_out <= duty_lo_reg;
                `PMC_ADDR_DUTY_HI: rdata_out <= {4'h0, duty_hi_reg};
                `PMC_ADDR_DEAD_LO: rdata_out <= dead_lo_reg;
                default: rdata_out <= {4'h0, dead_hi_reg};
            endcase
        end else
            rdata_out <= 8'h00;
    end
endmodule // pmc_channel
`default_nettype wire

// [tb/pmc_channel_checker.sv]
// port assertions for the pwm channel
`timescale 1ns/10ps
`default_nettype none
module pmc_channel_checker (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [2:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire ch0_irq_out,
    input wire ch2_fault_shutdown_out,
    input wire ch2_work_mode_out,
    input wire ch1_work_mode_out,
    input wire ch2_auto_reload_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire mw = wr_in && addr_in == 3'h0;
    wire cw = wr_in && addr_in == 3'h1;
    irq_gate_a: assert property (rd_in && addr_in == 3'h1 |=>
        (&rdata_out[7:6]) == $past(ch0_irq_out)) else $error("irq bad");
    irq_clear_a: assert property (cw && !wdata_in[7] |=>
        !ch0_irq_out) else $error("irq on");
    hi_zero_a: assert property (rd_in && addr_in == 3'h3 |=>
        rdata_out[7:4] == 4'h0) else $error("period high bits");
    rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data idle");
    ch2_fault_pin_off_a: assert property (mw && !wdata_in[7] |=>
        !ch2_fault_shutdown_out) else $error("ch2 shutdown");
    work_mode_a: assert property (mw |=> {ch2_work_mode_out,
        ch1_work_mode_out} == $past(wdata_in[6:5])) else $error("mode");
    reload_a: assert property (mw |=>
        ch2_auto_reload_out == $past(wdata_in[2])) else $error("reload");
    mode_read_a: assert property (rd_in && addr_in == 3'h0 |=>
        {rdata_out[6], rdata_out[3], rdata_out[2]} ==
        {ch2_work_mode_out, 1'b0, ch2_auto_reload_out}) else $error("rd");
endmodule // pmc_channel_checker
bind pmc_channel pmc_channel_checker chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ch0_irq_out(ch0_irq_out), .ch2_work_mode_out(ch2_work_mode_out),
    .ch2_fault_shutdown_out(ch2_fault_shutdown_out),
    .ch1_work_mode_out(ch1_work_mode_out),
    .ch2_auto_reload_out(ch2_auto_reload_out));
`default_nettype wire

// [tb/pmc_channel_tb_top.sv]
// self-checking bench of the pwm channel
`timescale 1ns/10ps
`default_nettype none
module pmc_channel_tb_top;
    reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pe = 1'b0;
    reg se = 1'b0, fpe = 1'b0, fp = 1'b0, f2 = 1'b1;
    reg [2:0] a = 3'h0;
    reg [1:0] fls = 2'h0;
    reg [7:0] wd = 8'h00, ctl;
    reg [31:0] seed = 32'h0000_0051;
    wire [7:0] rq;
    wire po, so, irq;
    integer num_errors = 0, checked = 0, cyc = 0, i, k, n, j, hp, hs;
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    pmc_channel dut (.ref_clk_in(clk), .rst_in(rst), .addr_in(a),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rq),
        .ch0_primary_enable_in(pe), .ch0_secondary_enable_in(se),
        .ch0_fault_level_select_in(fls), .ch0_fault_pin_enable_in(fpe),
        .ch0_fault_pin_in(fp), .ch2_fault_pin_in(f2), .ch0_primary_out(po),
        .ch0_secondary_out(so), .ch0_irq_out(irq),
        .ch2_fault_shutdown_out(), .ch2_work_mode_out(),
        .ch1_work_mode_out(), .ch2_auto_reload_out(),
        .ch1_auto_reload_out());
    // writable bits of each register
    function [7:0] msk(input [2:0] ad);
        msk = ad == 3'h0 ? 8'hf7 : ad == 3'h1 ? 8'h9f : ad[0] ? 8'h0f : 8'hff;
    endfunction
    task cmp(input [31:0] g, input [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr_reg(input [2:0] ad, input [7:0] d);
        wr <= 1'b1;
        a <= ad;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd_chk(input [2:0] ad, input [7:0] e);
        rd <= 1'b1;
        a <= ad;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp(rq, e);
        @(posedge clk);
    endtask
    task wait_irq;
        n = 0;
        @(negedge clk);
        while (irq !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n = n + 1;
        end
        j = cyc - j;
        @(posedge clk);
    endtask
    // clocks between two overflows
    task per_chk(input integer e);
        wait_irq;
        wr_reg(3'h1, ctl);
        j = cyc;
        wait_irq;
        wr_reg(3'h1, ctl);
        cmp(j + 2, e);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 8; i = i + 1)
            rd_chk(i[2:0], i ? 8'h00 : 8'h07);
        for (i = 0; i < 16; i = i + 1) begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            wr_reg(i[2:0], seed[7:0]);
            rd_chk(i[2:0], seed[7:0] & msk(i[2:0]));
        end
        wr_reg(3'h0, 8'h07);
        wr_reg(3'h3, 8'h00);
        wr_reg(3'h2, 8'h05);
        pe <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            ctl = 8'h80 | i[7:0];
            wr_reg(3'h1, ctl);
            per_chk(5 * (i ? 2 << (2 * i) : 1));
        end
        ctl = 8'h80;
        wr_reg(3'h1, ctl);
        wr_reg(3'h3, 8'h01);
        per_chk(5);
        wr_reg(3'h2, 8'h05);
        per_chk(261);
        wr_reg(3'h0, 8'h06);
        wr_reg(3'h3, 8'h00);
        wr_reg(3'h2, 8'h09);
        per_chk(261);
        wr_reg(3'h0, 8'h07);
        per_chk(9);
        wait_irq;
        rd_chk(3'h1, 8'hc0);
        wr_reg(3'h2, 8'd20);
        wr_reg(3'h5, 8'h00);
        wr_reg(3'h4, 8'h06);
        wr_reg(3'h7, 8'h00);
        wr_reg(3'h6, 8'h04);
        se <= 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            // channel is switched off around the work mode change
            pe <= 1'b0;
            se <= 1'b0;
            wr_reg(3'h0, k[2] ? 8'h17 : 8'h07);
            wr_reg(3'h1, {4'h0, k[1:0], 2'b00});
            pe <= 1'b1;
            se <= 1'b1;
            repeat (45) @(posedge clk);
            hp = 0;
            hs = 0;
            repeat (20) begin
                @(negedge clk);
                hp = hp + po;
                hs = hs + so;
            end
            cmp(hp, k[1] ? 14 : 6);
            cmp(hs, k[2] ? (k[0] ? 16 : 4) : 10);
        end
        pe <= 1'b0;
        se <= 1'b0;
        wr_reg(3'h1, 8'h10);
        fpe <= 1'b1;
        fp <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            fls <= k[1:0];
            repeat (5) @(negedge clk);
            cmp({po, so}, k);
            @(posedge clk);
        end
        rd_chk(3'h1, 8'h30);
        wr_reg(3'h1, 8'h10);
        rd_chk(3'h1, 8'h30);
        fp <= 1'b0;
        repeat (4) @(posedge clk);
        wr_reg(3'h1, 8'h10);
        rd_chk(3'h1, 8'h10);
        @(negedge clk);
        cmp({po, so}, 0);
        end_sim;
    end
endmodule // pmc_channel_tb_top
`default_nettype wire
